//--- design/sscp_pkg.sv
// Constants and types shared by the sensor serial configuration port
package sscp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SSCP_BANK_SEL_ADDR = 7'h00;
  localparam logic [6:0] SSCP_SOFT_RST_ADDR = 7'h03;
  localparam logic [6:0] SSCP_CTRL_ADDR = 7'h04;
  localparam logic [6:0] SSCP_STATUS_ADDR = 7'h7f;
  localparam logic [1:0] SSCP_BANK_CTRL = 2'h0;
  localparam logic [1:0] SSCP_BANK_SEL_RESET = 2'h0;
  localparam int SSCP_SOFT_RST_BIT = 0;
  localparam int SSCP_CTRL_PLL_EN_BIT = 0;
  localparam int SSCP_CTRL_MODE_BIT = 1;
  localparam int SSCP_CTRL_SW_REQ_BIT = 2;
  localparam logic SSCP_SOFT_RST_RESET = 1'b0;
  localparam logic [2:0] SSCP_CTRL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Serial frame bit counter positions
  // ----------------------------------------------------------------
  localparam logic [3:0] SSCP_CNT_DIR = 4'h0;
  localparam logic [3:0] SSCP_CNT_ADDR_LSB = 4'h7;
  localparam logic [3:0] SSCP_CNT_DATA_MSB = 4'h8;
  localparam logic [3:0] SSCP_CNT_DATA_LSB = 4'hf;
  localparam logic SSCP_DIR_WRITE = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SSCP_CLK_PERIOD_NS = 50;
  localparam int SSCP_PLL_LOCK_TIME_US = 200;
  localparam int SSCP_PLL_LOCK_CYCLES = (SSCP_PLL_LOCK_TIME_US * 1000) / SSCP_CLK_PERIOD_NS;
  localparam logic [11:0] SSCP_PLL_LOCK_COUNT = SSCP_PLL_LOCK_CYCLES[11:0];

  // ----------------------------------------------------------------
  // Sensor states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSCP_SOFT_RESET,
    SSCP_IDLE,
    SSCP_EXPOSURE
  } sscp_state_e;

endpackage : sscp_pkg

//--- design/sscp_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module sscp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule : sscp_sync

//--- design/sscp_regmem.sv
// Four banks of 128 byte registers, write on falling edge, registered read
`timescale 1ns/1ns
module sscp_regmem (
  // Serial clock
  input wire logic clk_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [8:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // Read port
  input wire logic [8:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem [0:511];

  // Commit on the falling edge that ends the last data bit
  always_ff @(negedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rd_data_out <= mem[rd_addr_in];
  end

endmodule : sscp_regmem

//--- design/sscp_top.sv
// Sensor serial configuration port with startup sequencing
//
// Function
// - Releasing hard reset enters soft reset, never idle directly.
// - PLL enabled in soft reset locks after 200 us; idle only after lock.
// - Idle stays inactive until an exposure request per control mode.
// - Access is direction bit, 7-bit address, then data bytes.
// - Direction bit 1 writes, 0 reads.
// - Burst address advances by one after every 8 data bits.
// - Serial clock ignored while select is high.
// - Serial input sampled on rising serial clock edges.
// - Address and data travel MSB first.
// - Write commits on falling edge ending the data LSB.
// - Read data launched MSB first on falling edges after address LSB.
// - Serial output high impedance unless sending read data.
// - Burst read returns successive addresses while clocks continue.
// - Storage is four banks of 128 byte registers.
// - Address zero holds 2-bit bank selector, reachable from every bank.
// - Nonzero addresses target the currently selected bank.
`timescale 1ns/1ns
module sscp_top
  import sscp_pkg::*;
(
  // Main clock and hard reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Serial link
  input wire logic spi_clk_in,
  input wire logic serial_select_n_in,
  input wire logic spi_data_in,
  output logic spi_data_out,
  output logic spi_data_oe_out,
  // Exposure control
  input wire logic exposure_request_in,
  output logic exposure_active_out,
  // Status
  output logic [1:0] sensor_state_out,
  output logic pll_locked_out
);

  // ----------------------------------------------------------------
  // Serial domain declarations
  // ----------------------------------------------------------------
  logic link_rst_n;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic dir;
  logic [6:0] addr;
  logic [6:0] addr_inc;
  logic [6:0] addr_full;
  logic [7:0] shift_in;
  logic [7:0] byte_full;
  logic wr_req;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [6:0] rd_addr_q;
  logic [1:0] rd_bank_q;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;
  logic [7:0] tx_shift;
  logic tx_oe;
  logic [1:0] bank_sel;
  logic soft_rst_n_reg;
  logic [2:0] ctrl_reg;
  logic [2:0] status_link;
  logic [2:0] status_prev;
  logic [2:0] status_hold;
  logic status_steady;
  logic at_addr_lsb;
  logic at_data_lsb;
  logic wr_is_bank_sel;
  logic wr_is_soft_rst;
  logic wr_is_ctrl;
  logic wr_is_status;
  logic mem_wr_en;

  // Counter and shifters are cleared while the part is deselected
  assign link_rst_n = resetn_in & ~serial_select_n_in;

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // Array index of a register: bank above the 7-bit address
  function automatic logic [8:0] mem_index(input logic [1:0] bank,
    input logic [6:0] reg_addr);
    return {bank, reg_addr};
  endfunction : mem_index

  // Control and status registers live in bank 0 only
  function automatic logic is_ctrl_reg(input logic [1:0] bank, input logic [6:0] reg_addr,
    input logic [6:0] target);
    return (bank == SSCP_BANK_CTRL) && (reg_addr == target);
  endfunction : is_ctrl_reg

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  assign at_addr_lsb = (bit_cnt == SSCP_CNT_ADDR_LSB);
  assign at_data_lsb = (bit_cnt == SSCP_CNT_DATA_LSB);
  assign next_bit_cnt = at_data_lsb ? SSCP_CNT_DATA_MSB : bit_cnt + 4'h1;
  assign addr_full = {addr[5:0], spi_data_in};
  assign byte_full = {shift_in[6:0], spi_data_in};
  assign addr_inc = addr + 7'h01;
  // Prefetch the first byte at the address LSB, the next at each data LSB
  assign rd_addr = at_addr_lsb ? addr_full : addr_inc;

  // ----------------------------------------------------------------
  // Receive on rising edges
  // ----------------------------------------------------------------
  always_ff @(posedge spi_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= SSCP_CNT_DIR;
      dir <= 1'b0;
      addr <= 7'h00;
      shift_in <= 8'h00;
      wr_req <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      rd_addr_q <= 7'h00;
      rd_bank_q <= 2'h0;
    end else begin
      bit_cnt <= next_bit_cnt;
      if (bit_cnt == SSCP_CNT_DIR) begin
        dir <= spi_data_in;
      end
      if (bit_cnt != SSCP_CNT_DIR && bit_cnt <= SSCP_CNT_ADDR_LSB) begin
        addr <= addr_full;
      end else if (at_data_lsb) begin
        addr <= addr_inc;
      end
      if (bit_cnt >= SSCP_CNT_DATA_MSB) begin
        shift_in <= byte_full;
      end
      wr_req <= at_data_lsb & (dir == SSCP_DIR_WRITE);
      if (at_data_lsb) begin
        wr_addr <= addr;
        wr_data <= byte_full;
      end
      if (at_addr_lsb || at_data_lsb) begin
        rd_addr_q <= rd_addr;
        rd_bank_q <= bank_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_is_bank_sel = (wr_addr == SSCP_BANK_SEL_ADDR);
  assign wr_is_soft_rst = is_ctrl_reg(bank_sel, wr_addr, SSCP_SOFT_RST_ADDR);
  assign wr_is_ctrl = is_ctrl_reg(bank_sel, wr_addr, SSCP_CTRL_ADDR);
  assign wr_is_status = is_ctrl_reg(bank_sel, wr_addr, SSCP_STATUS_ADDR);
  assign mem_wr_en = wr_req & ~wr_is_bank_sel & ~wr_is_status;

  // Configuration survives deselect; only the hard reset clears it
  always_ff @(negedge spi_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bank_sel <= SSCP_BANK_SEL_RESET;
      soft_rst_n_reg <= SSCP_SOFT_RST_RESET;
      ctrl_reg <= SSCP_CTRL_RESET;
    end else if (wr_req) begin
      if (wr_is_bank_sel) begin
        bank_sel <= wr_data[1:0];
      end
      if (wr_is_soft_rst) begin
        soft_rst_n_reg <= wr_data[SSCP_SOFT_RST_BIT];
      end
      if (wr_is_ctrl) begin
        ctrl_reg <= wr_data[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------
  sscp_regmem u_regmem (
    .clk_in(spi_clk_in),
    .wr_en_in(mem_wr_en),
    .wr_addr_in(mem_index(bank_sel, wr_addr)),
    .wr_data_in(wr_data),
    .rd_addr_in(mem_index(bank_sel, rd_addr)),
    .rd_data_out(mem_rdata)
  );

  // Selector and live status bypass the array
  assign rd_byte = (rd_addr_q == SSCP_BANK_SEL_ADDR) ? {6'h00, bank_sel} :
    is_ctrl_reg(rd_bank_q, rd_addr_q, SSCP_STATUS_ADDR) ?
    {5'h00, status_hold} : mem_rdata;

  // ----------------------------------------------------------------
  // Transmit on falling edges
  // ----------------------------------------------------------------
  always_ff @(negedge spi_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_shift <= 8'h00;
      tx_oe <= 1'b0;
    end else if (bit_cnt == SSCP_CNT_DATA_MSB) begin
      tx_shift <= rd_byte;
      tx_oe <= (dir != SSCP_DIR_WRITE);
    end else begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  assign spi_data_out = tx_shift[7];
  assign spi_data_oe_out = tx_oe;

  // Status into the serial domain for readback
  sscp_sync #(.W(3)) u_status_sync (
    .clk_in(spi_clk_in),
    .resetn_in(resetn_in),
    .d_in({pll_locked_out, sensor_state_out}),
    .q_out(status_link)
  );

  // The state code may change two bits at once, so a status value is
  // taken only when two synchronised samples in a row agree
  assign status_steady = (status_link == status_prev);

  always_ff @(posedge spi_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_prev <= 3'h0;
      status_hold <= 3'h0;
    end else begin
      status_prev <= status_link;
      if (status_steady) begin
        status_hold <= status_link;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main clock domain
  // ----------------------------------------------------------------
  logic main_rst_n;
  logic [4:0] ctrl_sync;
  logic [3:0] ctrl_prev;
  logic [3:0] ctrl_word;
  logic soft_rst_n;
  logic pll_en;
  logic mode_sw;
  logic sw_req;
  logic pin_req;
  logic exp_req;
  logic [11:0] lock_cnt;
  sscp_state_e state;
  sscp_state_e next_state;

  // ----------------------------------------------------------------
  // Main clock reset: asserted at once, released after two edges
  // ----------------------------------------------------------------
  sscp_sync #(.W(1)) u_rst_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(1'b1),
    .q_out(main_rst_n)
  );

  sscp_sync #(.W(5)) u_ctrl_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in({exposure_request_in, ctrl_reg[SSCP_CTRL_SW_REQ_BIT],
      ctrl_reg[SSCP_CTRL_MODE_BIT], ctrl_reg[SSCP_CTRL_PLL_EN_BIT], soft_rst_n_reg}),
    .q_out(ctrl_sync)
  );

  // Control bits written together are used together, never half old
  always_ff @(posedge clk_in or negedge main_rst_n) begin
    if (!main_rst_n) begin
      ctrl_prev <= {SSCP_CTRL_RESET, SSCP_SOFT_RST_RESET};
      ctrl_word <= {SSCP_CTRL_RESET, SSCP_SOFT_RST_RESET};
    end else begin
      ctrl_prev <= ctrl_sync[3:0];
      if (ctrl_sync[3:0] == ctrl_prev) begin
        ctrl_word <= ctrl_sync[3:0];
      end
    end
  end

  assign soft_rst_n = ctrl_word[0];
  assign pll_en = ctrl_word[1];
  assign mode_sw = ctrl_word[2];
  assign sw_req = ctrl_word[3];
  assign pin_req = ctrl_sync[4];
  assign exp_req = mode_sw ? sw_req : pin_req;

  // PLL lock model: lock follows enable after the lock time
  always_ff @(posedge clk_in or negedge main_rst_n) begin
    if (!main_rst_n) begin
      lock_cnt <= 12'h000;
      pll_locked_out <= 1'b0;
    end else if (!pll_en) begin
      lock_cnt <= 12'h000;
      pll_locked_out <= 1'b0;
    end else if (lock_cnt == SSCP_PLL_LOCK_COUNT) begin
      pll_locked_out <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 12'h001;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      SSCP_SOFT_RESET: begin
        if (soft_rst_n && pll_locked_out) begin
          next_state = SSCP_IDLE;
        end
      end
      SSCP_IDLE: begin
        if (!soft_rst_n) begin
          next_state = SSCP_SOFT_RESET;
        end else if (exp_req) begin
          next_state = SSCP_EXPOSURE;
        end
      end
      SSCP_EXPOSURE: begin
        if (!soft_rst_n) begin
          next_state = SSCP_SOFT_RESET;
        end else if (!exp_req) begin
          next_state = SSCP_IDLE;
        end
      end
      default: begin
        next_state = SSCP_SOFT_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge main_rst_n) begin
    if (!main_rst_n) begin
      state <= SSCP_SOFT_RESET;
      sensor_state_out <= 2'h0;
      exposure_active_out <= 1'b0;
    end else begin
      state <= next_state;
      sensor_state_out <= next_state;
      exposure_active_out <= (next_state == SSCP_EXPOSURE);
    end
  end

endmodule : sscp_top

//--- sim/sscp_checker.sv
// Assertion checker bound to the serial configuration port top
`timescale 1ns/1ns
module sscp_checker (
  // Main clock domain
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic exposure_request_in,
  input wire logic exposure_active_out,
  input wire logic [1:0] sensor_state_out,
  input wire logic pll_locked_out,
  // Serial link
  input wire logic spi_clk_in,
  input wire logic serial_select_n_in,
  input wire logic spi_data_in,
  input wire logic spi_data_out,
  input wire logic spi_data_oe_out
);
  logic [3:0] bit_cnt;
  logic dir_wr;
  // Frame position, saturating once the data phase is reached
  always_ff @(posedge spi_clk_in or posedge serial_select_n_in) begin
    if (serial_select_n_in) begin
      bit_cnt <= 4'h0;
      dir_wr <= 1'b0;
    end else begin
      bit_cnt <= (bit_cnt == 4'h8) ? bit_cnt : bit_cnt + 4'h1;
      dir_wr <= (bit_cnt == 4'h0) ? spi_data_in : dir_wr;
    end
  end
  chk_soft_after_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(resetn_in) |-> sensor_state_out == 2'h0) else $error("not soft reset");
  chk_idle_needs_lock: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(sensor_state_out == 2'h1) |-> pll_locked_out) else $error("idle unlocked");
  chk_exp_flag_state: assert property (@(posedge clk_in) disable iff (!resetn_in)
    exposure_active_out == (sensor_state_out == 2'h2)) else $error("exposure flag");
  chk_exp_from_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(exposure_active_out) |-> $past(sensor_state_out) == 2'h1) else $error("not idle");
  chk_exp_needs_req: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(exposure_active_out) |-> $past(exposure_request_in, 2) ||
    $past(exposure_request_in, 3) || $past(exposure_request_in, 4)) else $error("no request");
  chk_oe_deselect: assert property (@(posedge clk_in) disable iff (!resetn_in)
    serial_select_n_in |-> !spi_data_oe_out) else $error("oe while deselected");
  chk_oe_read_data: assert property (@(posedge spi_clk_in)
    disable iff (!resetn_in || serial_select_n_in)
    bit_cnt == 4'h8 && !dir_wr |-> spi_data_oe_out) else $error("read not driven");
  chk_oe_quiet: assert property (@(posedge spi_clk_in)
    disable iff (!resetn_in || serial_select_n_in)
    bit_cnt != 4'h8 || dir_wr |-> !spi_data_oe_out) else $error("oe outside read");
endmodule : sscp_checker

bind sscp_top sscp_checker i_sscp_checker (.clk_in(clk_in), .resetn_in(resetn_in),
  .exposure_request_in(exposure_request_in), .exposure_active_out(exposure_active_out),
  .sensor_state_out(sensor_state_out), .pll_locked_out(pll_locked_out),
  .spi_clk_in(spi_clk_in), .serial_select_n_in(serial_select_n_in),
  .spi_data_in(spi_data_in), .spi_data_out(spi_data_out), .spi_data_oe_out(spi_data_oe_out));

//--- sim/sscp_spi_master.sv
// Behavioural serial master that configures the port
`timescale 1ns/1ns
module sscp_spi_master (
  // Link outputs
  output logic spi_clk_out,
  output logic select_n_out,
  output logic mosi_out,
  // Read data
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  localparam int HALF_NS = 15;
  logic [7:0] wdata [8];
  logic [7:0] rdata [8];
  initial begin
    spi_clk_out = 1'b0;
    select_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // One frame of nb bits; the clock stands low between frames
  task automatic xfer(input logic dir, input logic [6:0] addr, input int nb);
    logic [7:0] hdr;
    int k;
    hdr = {dir, addr};
    select_n_out <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      k = (i < 8) ? 0 : (i - 8) / 8;
      mosi_out <= (i < 8) ? hdr[7 - i] : wdata[k][7 - (i % 8)];
      #HALF_NS;
      if (i >= 8) rdata[k][7 - (i % 8)] = miso_oe_in ? miso_in : ~miso_in;
      spi_clk_out <= 1'b1;
      #HALF_NS;
      spi_clk_out <= 1'b0;
    end
    #HALF_NS;
    select_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    // Select stands high a full period before any next frame
    #(2 * HALF_NS);
  endtask : xfer
  // Clocks with select high, which the port must ignore
  task automatic stray_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      mosi_out <= ~mosi_out;
      #HALF_NS;
      spi_clk_out <= 1'b1;
      #HALF_NS;
      spi_clk_out <= 1'b0;
    end
  endtask : stray_clocks
endmodule : sscp_spi_master

//--- sim/sscp_top_tb.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ns
module sscp_top_tb;
  import sscp_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic exposure_request_in = 1'b0;
  wire logic spi_clk, select_n, mosi, miso, miso_oe;
  logic exposure_active_out;
  logic pll_locked_out;
  logic [1:0] sensor_state_out;
  int n_errors = 0;
  int comparisons = 0;
  always #25 clk_in = ~clk_in;
  sscp_top i_sscp_top (.clk_in(clk_in), .resetn_in(resetn_in), .spi_clk_in(spi_clk),
    .serial_select_n_in(select_n), .spi_data_in(mosi), .spi_data_out(miso),
    .spi_data_oe_out(miso_oe), .exposure_request_in(exposure_request_in),
    .exposure_active_out(exposure_active_out), .sensor_state_out(sensor_state_out),
    .pll_locked_out(pll_locked_out));
  sscp_spi_master i_sscp_spi_master (.spi_clk_out(spi_clk), .select_n_out(select_n),
    .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [6:0] addr, input logic [7:0] d);
    i_sscp_spi_master.wdata[0] = d;
    i_sscp_spi_master.xfer(1'b1, addr, 16);
  endtask : wr
  task automatic rd_chk(input string what, input logic [6:0] addr, input logic [7:0] exp);
    i_sscp_spi_master.xfer(1'b0, addr, 16);
    check(what, i_sscp_spi_master.rdata[0], exp);
  endtask : rd_chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #2000000;
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (20) @(negedge clk_in);
    check("state", {6'h0, sensor_state_out}, 8'h00);
    rd_chk("bank select", 7'h00, 8'h00);
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      wr(7'h00, 8'(b));
      wr(7'h20, 8'h40 + 8'(b));
    end
    for (int b = 3; b >= 0; b--) begin
      wr(7'h00, 8'(b));
      rd_chk("bank select", 7'h00, 8'(b));
      rd_chk("banked data", 7'h20, 8'h40 + 8'(b));
    end
    $display("test banks done");
    wr(7'h00, 8'h01);
    for (int k = 0; k < 4; k++) i_sscp_spi_master.wdata[k] = 8'h11 * 8'(k + 1);
    i_sscp_spi_master.xfer(1'b1, 7'h10, 40);
    i_sscp_spi_master.xfer(1'b0, 7'h10, 40);
    for (int k = 0; k < 4; k++) check("burst", i_sscp_spi_master.rdata[k], 8'h11 * 8'(k + 1));
    i_sscp_spi_master.wdata[0] = 8'hee;
    i_sscp_spi_master.xfer(1'b1, 7'h10, 15);
    rd_chk("abandoned write", 7'h10, 8'h11);
    i_sscp_spi_master.stray_clocks(9);
    rd_chk("stray clocks", 7'h11, 8'h22);
    $display("test bursts done");
    wr(7'h00, 8'h00);
    wr(SSCP_CTRL_ADDR, 8'h01);
    repeat (3990) @(negedge clk_in);
    check("early lock", {7'h0, pll_locked_out}, 8'h00);
    for (int i = 0; i < 100 && pll_locked_out !== 1'b1; i++) @(negedge clk_in);
    check("lock", {7'h0, pll_locked_out}, 8'h01);
    repeat (20) @(negedge clk_in);
    check("soft reset held", {6'h0, sensor_state_out}, 8'h00);
    wr(SSCP_SOFT_RST_ADDR, 8'h01);
    repeat (20) @(negedge clk_in);
    check("idle", {6'h0, sensor_state_out}, 8'h01);
    wr(SSCP_STATUS_ADDR, 8'hff);
    rd_chk("status", SSCP_STATUS_ADDR, 8'h05);
    repeat (50) @(negedge clk_in);
    check("idle quiet", {6'h0, sensor_state_out}, 8'h01);
    @(posedge clk_in);
    exposure_request_in <= 1'b1;
    for (int i = 0; i < 10 && exposure_active_out !== 1'b1; i++) @(negedge clk_in);
    check("exposure", {6'h0, sensor_state_out}, 8'h02);
    wr(SSCP_CTRL_ADDR, 8'h03);
    repeat (20) @(negedge clk_in);
    check("pin ignored", {6'h0, sensor_state_out}, 8'h01);
    check("exposure off", {7'h0, exposure_active_out}, 8'h00);
    wr(SSCP_CTRL_ADDR, 8'h07);
    repeat (20) @(negedge clk_in);
    check("soft request", {6'h0, sensor_state_out}, 8'h02);
    check("exposure on", {7'h0, exposure_active_out}, 8'h01);
    $display("test startup done");
    summarize();
  end
endmodule : sscp_top_tb
